/* design/flash_self_program_sequencer.v */
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "flash_spm_defines.vh"

module flash_self_program_sequencer #(
    parameter WORD_BITS = 5,
    parameter PROG_CYCLES = `PROG_CYCLES
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Core side
    input wire self_program_enable,
    input wire store_program_strobe,
    input wire load_program_strobe,
    output reg core_stall,
    output reg [15:0] lpm_byte_addr,
    output reg lpm_fuse_blocked,
    // EEPROM status
    input wire eeprom_write_busy_bit,
    // Flash array
    output reg flash_erase,
    output reg flash_write,
    output reg [15-WORD_BITS-1:0] flash_page,
    output reg [WORD_BITS-1:0] flash_word,
    output reg [15:0] flash_wdata
);
    localparam PAGE_BITS = 15 - WORD_BITS;
    localparam ST_IDLE = 2'd0;
    localparam ST_ERASE = 2'd1;
    localparam ST_WRITE = 2'd2;
    localparam ST_DUMP = 2'd3;

    reg [7:0] program_store_control_reg_ff;
    reg [15:0] ptr_ff;
    reg [15:0] data_register_pair_ff;
    reg [2:0] window_ff;
    reg [1:0] state_ff;
    reg [31:0] timer_ff;
    reg [WORD_BITS-1:0] dump_ff;
    reg aw_hold_ff;
    reg w_hold_ff;
    reg [3:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg load_busy_ff;
    reg buf_clear;
    reg buf_load;

    wire [WORD_BITS-1:0] word_in_page_field = ptr_ff[WORD_BITS:1];
    wire [PAGE_BITS-1:0] page_index_field = ptr_ff[15:WORD_BITS+1];
    wire armed = window_ff != 3'd0;
    wire go = armed && store_program_strobe && !self_program_enable
        && !eeprom_write_busy_bit;
    wire [7:0] cmd = program_store_control_reg_ff;
    wire [15:0] buf_rd_data;
    wire buf_rd_valid;
    wire wr_fire = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

    page_buffer #(.WORD_BITS(WORD_BITS)) u_buf (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clear(buf_clear),
        .load(buf_load),
        .load_addr(word_in_page_field),
        .load_data(data_register_pair_ff),
        .rd_addr(dump_ff),
        .rd_data(buf_rd_data),
        .rd_valid(buf_rd_valid),
        .dup_load()
    );

    always @* begin
        buf_load = go && cmd == `CMD_LOAD;
        buf_clear = (state_ff == ST_DUMP && dump_ff == {WORD_BITS{1'b1}})
            || (wr_fire && aw_addr_ff == `ADDR_CTRL && w_strb_ff[0]
                && w_data_ff[`BIT_CLEAR_BUF])
            || (load_busy_ff && eeprom_write_busy_bit);
    end

    // Write channel: address and data are taken independently, in any order.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            aw_addr_ff <= 4'h0;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_ff[1:0] != 2'b00) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
            end
        end
    end

    // Register writes, window and sequencer.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            program_store_control_reg_ff <= `CTRL_RESET;
            ptr_ff <= 16'h0;
            data_register_pair_ff <= 16'h0;
            window_ff <= 3'd0;
            state_ff <= ST_IDLE;
            timer_ff <= 32'd0;
            dump_ff <= {WORD_BITS{1'b0}};
            load_busy_ff <= 1'b0;
            core_stall <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_page <= {PAGE_BITS{1'b0}};
            flash_word <= {WORD_BITS{1'b0}};
            flash_wdata <= 16'h0;
        end else begin
            flash_write <= 1'b0;
            if (window_ff != 3'd0) begin
                window_ff <= window_ff - 3'd1;
            end
            if (window_ff == 3'd1 && !go) begin
                program_store_control_reg_ff <= `CTRL_RESET;
            end
            if (buf_clear) begin
                load_busy_ff <= 1'b0;
            end
            if (wr_fire && state_ff == ST_IDLE) begin
                case (aw_addr_ff)
                    `ADDR_CTRL: begin
                        if (w_strb_ff[0] && !eeprom_write_busy_bit) begin
                            // The clear acts at once; leaving the enable bit armed would turn
                            // the following store into an unwanted buffer load.
                            if (w_data_ff[`BIT_CLEAR_BUF]) begin
                                program_store_control_reg_ff <= `CTRL_RESET;
                                window_ff <= 3'd0;
                            end else begin
                                program_store_control_reg_ff <= w_data_ff[7:0];
                                window_ff <= w_data_ff[`BIT_ENABLE] ? `ARM_WINDOW_CYCLES : 3'd0;
                            end
                        end
                    end
                    `ADDR_PTR: begin
                        if (w_strb_ff[0]) ptr_ff[7:0] <= w_data_ff[7:0];
                        if (w_strb_ff[1]) ptr_ff[15:8] <= w_data_ff[15:8];
                    end
                    `ADDR_DATA: begin
                        if (w_strb_ff[0]) data_register_pair_ff[7:0] <= w_data_ff[7:0];
                        if (w_strb_ff[1]) data_register_pair_ff[15:8] <= w_data_ff[15:8];
                    end
                    default: begin
                    end
                endcase
            end
            case (state_ff)
                ST_IDLE: begin
                    if (go) begin
                        window_ff <= 3'd0;
                        program_store_control_reg_ff <= `CTRL_RESET;
                        case (cmd)
                            `CMD_LOAD: load_busy_ff <= 1'b1;
                            `CMD_ERASE: begin
                                // Word bits and data pair are not used here.
                                flash_page <= page_index_field;
                                flash_erase <= 1'b1;
                                core_stall <= 1'b1;
                                timer_ff <= PROG_CYCLES;
                                state_ff <= ST_ERASE;
                            end
                            `CMD_WRITE: begin
                                flash_page <= page_index_field;
                                core_stall <= 1'b1;
                                dump_ff <= {WORD_BITS{1'b0}};
                                state_ff <= ST_DUMP;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_DUMP: begin
                    // Unloaded words are written as erased.
                    flash_write <= 1'b1;
                    flash_word <= dump_ff;
                    flash_wdata <= buf_rd_data;
                    dump_ff <= dump_ff + {{(WORD_BITS-1){1'b0}}, 1'b1};
                    if (dump_ff == {WORD_BITS{1'b1}}) begin
                        load_busy_ff <= 1'b0;
                        timer_ff <= PROG_CYCLES;
                        state_ff <= ST_WRITE;
                    end
                end
                ST_ERASE, ST_WRITE: begin
                    if (timer_ff <= 32'd1) begin
                        flash_erase <= 1'b0;
                        core_stall <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else begin
                        timer_ff <= timer_ff - 32'd1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Byte address for program reads and fuse-read blocking.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            lpm_byte_addr <= 16'h0;
            lpm_fuse_blocked <= 1'b0;
        end else begin
            if (load_program_strobe) lpm_byte_addr <= ptr_ff;
            lpm_fuse_blocked <= eeprom_write_busy_bit;
        end
    end

    // Read channel.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `ADDR_CTRL: s_axi_rdata <= {24'h0, program_store_control_reg_ff};
                    `ADDR_PTR: s_axi_rdata <= {16'h0, ptr_ff};
                    `ADDR_DATA: s_axi_rdata <= {16'h0, data_register_pair_ff};
                    `ADDR_STAT: s_axi_rdata <= {29'h0, eeprom_write_busy_bit,
                        armed, state_ff != ST_IDLE};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // flash_self_program_sequencer

/* design/flash_spm_defines.vh */
`ifndef FLASH_SPM_DEFINES_VH
`define FLASH_SPM_DEFINES_VH

// AXI4-Lite register byte addresses.
`define ADDR_CTRL 4'h0
`define ADDR_PTR 4'h4
`define ADDR_DATA 4'h8
`define ADDR_STAT 4'hc

// Control register fields and command codes.
`define CTRL_WIDTH 8
`define CMD_LOAD 8'h01
`define CMD_ERASE 8'h03
`define CMD_WRITE 8'h05
`define BIT_ENABLE 0
`define BIT_CLEAR_BUF 4
`define CTRL_RESET 8'h00

// Status register fields.
`define STAT_BUSY 0
`define STAT_ARMED 1
`define STAT_BLOCKED 2

// Timed window and programming time.
`define ARM_WINDOW_CYCLES 3'd4
`define CLK_MHZ 25
`define PROG_TIME_MIN_US 3700
`define PROG_TIME_MAX_US 4500
`define PROG_CYCLES (`PROG_TIME_MIN_US * `CLK_MHZ)

`endif

/* design/page_buffer.v */
`timescale 1ns/1ps
`include "flash_spm_defines.vh"

module page_buffer #(
    parameter WORD_BITS = 5
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Control
    input wire clear,
    input wire load,
    input wire [WORD_BITS-1:0] load_addr,
    input wire [15:0] load_data,
    // Readout
    input wire [WORD_BITS-1:0] rd_addr,
    output wire [15:0] rd_data,
    output wire rd_valid,
    output wire dup_load
);
    localparam DEPTH = 1 << WORD_BITS;
    reg [15:0] mem [0:DEPTH-1];
    reg [DEPTH-1:0] used_ff;
    // A cleared location reads as erased flash.
    assign rd_data = used_ff[rd_addr] ? mem[rd_addr] : 16'hffff;
    assign rd_valid = used_ff[rd_addr];
    // A load that meets a clear lands in the freshly cleared buffer, so the set wins.
    wire take = load && (clear || !used_ff[load_addr]);
    assign dup_load = load && !take;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            used_ff <= {DEPTH{1'b0}};
        end else begin
            if (clear) begin
                used_ff <= {DEPTH{1'b0}};
            end
            if (take) begin
                used_ff[load_addr] <= 1'b1;
            end
        end
    end

    always @(posedge core_clk) begin
        if (take) begin
            mem[load_addr] <= load_data;
        end
    end
endmodule // page_buffer

/* verification/spm_seq_asserts.sv */
`timescale 1ns/1ps
module spm_seq_asserts #(
    parameter WORD_BITS = 5,
    parameter PROG_CYCLES = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Observed ports
    input wire logic self_program_enable,
    input wire logic eeprom_write_busy_bit,
    input wire logic core_stall,
    input wire logic lpm_fuse_blocked,
    input wire logic flash_erase,
    input wire logic flash_write
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] er_cnt_ff;
    logic [7:0] wr_cnt_ff;
    // Counters stand in for long repetitions, which the tools would unroll.
    always @(posedge core_clk) begin
        er_cnt_ff <= (flash_erase && !sys_rst) ? er_cnt_ff + 32'd1 : 32'd0;
        wr_cnt_ff <= ((core_stall || flash_write) && !sys_rst) ?
            wr_cnt_ff + {7'd0, flash_write} : 8'd0;
    end
    chk_fuse_gate: assert property (
        self_program_enable && $past(self_program_enable, 3) |-> !$rose(core_stall))
        else $error("stall started while the enable fuse is off");
    chk_busy_block: assert property (
        $past(eeprom_write_busy_bit) && $past(eeprom_write_busy_bit, 2) |-> !$rose(core_stall))
        else $error("command started while the eeprom was busy");
    chk_fuse_read: assert property (eeprom_write_busy_bit [*2] |-> lpm_fuse_blocked)
        else $error("fuse reads not blocked during eeprom write");
    chk_erase_stall: assert property (flash_erase |-> core_stall)
        else $error("core runs during erase");
    chk_write_stall: assert property (flash_write |-> core_stall)
        else $error("core runs during page write");
    chk_stall_end: assert property (
        $fell(core_stall) |-> !flash_erase && !flash_write)
        else $error("core released before the operation ended");
    chk_erase_len: assert property ($fell(flash_erase) |-> er_cnt_ff == PROG_CYCLES)
        else $error("erase length wrong");
    chk_write_words: assert property (
        $fell(core_stall) |-> wr_cnt_ff == 8'd0 || wr_cnt_ff == 8'(1 << WORD_BITS))
        else $error("page write did not cover the whole page");
    cov_erase: cover property ($rose(flash_erase));
    cov_write: cover property ($rose(flash_write));
    cov_block: cover property (eeprom_write_busy_bit && lpm_fuse_blocked);
endmodule // spm_seq_asserts

bind flash_self_program_sequencer spm_seq_asserts #(
    .WORD_BITS(WORD_BITS), .PROG_CYCLES(PROG_CYCLES)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .self_program_enable(self_program_enable),
    .eeprom_write_busy_bit(eeprom_write_busy_bit), .core_stall(core_stall),
    .lpm_fuse_blocked(lpm_fuse_blocked), .flash_erase(flash_erase),
    .flash_write(flash_write));

/* verification/core_model.sv */
`timescale 1ns/1ps
module core_model (
    // Clock
    input wire logic core_clk,
    // Core activity
    input wire logic core_stall,
    output logic store_program_strobe,
    output logic load_program_strobe
);
    initial begin
        store_program_strobe = 1'b0;
        load_program_strobe = 1'b0;
    end
    // A stalled core executes nothing, so no store leaves it then.
    task automatic spm(input int gap);
        repeat (gap) @(posedge core_clk);
        store_program_strobe <= !core_stall;
        @(posedge core_clk);
        store_program_strobe <= 1'b0;
    endtask
    task automatic lpm();
        load_program_strobe <= 1'b1;
        @(posedge core_clk);
        load_program_strobe <= 1'b0;
    endtask
endmodule // core_model

/* verification/test_flash_self_program_sequencer.sv */
`timescale 1ns/1ps
`include "flash_spm_defines.vh"
module test_flash_self_program_sequencer;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic fuse = 1'b1;
    logic ee_busy = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, store, load, stall, blocked, erase, fwr;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] lpm_addr, fdata;
    wire [9:0] fpage;
    wire [4:0] fword;
    logic [15:0] seen [32];
    logic [9:0] last_page;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_er = 0;
    int n_wr = 0;
    always #20 core_clk = ~core_clk;
    flash_self_program_sequencer #(.PROG_CYCLES(20)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .self_program_enable(fuse), .store_program_strobe(store), .load_program_strobe(load),
        .core_stall(stall), .lpm_byte_addr(lpm_addr), .lpm_fuse_blocked(blocked),
        .eeprom_write_busy_bit(ee_busy), .flash_erase(erase), .flash_write(fwr),
        .flash_page(fpage), .flash_word(fword), .flash_wdata(fdata));
    core_model core (.core_clk(core_clk), .core_stall(stall), .store_program_strobe(store),
        .load_program_strobe(load));
    always @(posedge core_clk) begin
        if ($rose(erase)) begin
            n_er++;
            last_page <= fpage;
        end
        if (fwr) begin
            n_wr++;
            seen[fword] <= fdata;
            last_page <= fpage;
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic hang;
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        stop_test();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        if (n >= 40) hang();
        chk({30'h0, bresp}, {30'h0, r});
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        if (n >= 40) hang();
        chk(rdata & m, e);
        chk({30'h0, rresp}, {30'h0, r});
    endtask
    task automatic cmd(input logic [7:0] c, input int gap);
        wr(`ADDR_CTRL, {24'h0, c});
        core.spm(gap);
    endtask
    task automatic ld(input logic [15:0] p, input logic [15:0] d);
        wr(`ADDR_PTR, {16'h0, p});
        wr(`ADDR_DATA, {16'h0, d});
        cmd(`CMD_LOAD, 0);
    endtask
    // Waits for a stall to begin (required when busy is set) and then to end.
    task automatic settle(input logic busy);
        int n;
        n = 0;
        while (!stall && n < 8) begin
            @(posedge core_clk);
            n++;
        end
        if (busy && n >= 8) hang();
        n = 0;
        while (stall && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 200) hang();
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd(`ADDR_CTRL, 32'hff, {24'h0, `CTRL_RESET}, 2'b00);
        wr(`ADDR_PTR, {16'h0, 10'd5, 5'd7, 1'b1});
        cmd(`CMD_ERASE, 0);
        settle(1'b0);
        chk(n_er, 0);
        fuse <= 1'b0;
        cmd(`CMD_ERASE, 0);
        rd(`ADDR_STAT, 32'h1, 32'h1, 2'b00);
        settle(1'b1);
        chk(n_er, 1);
        chk({22'h0, last_page}, 32'd5);
        cmd(`CMD_ERASE, 6);
        settle(1'b0);
        rd(`ADDR_CTRL, 32'hff, 32'h0, 2'b00);
        ld({10'd5, 5'd9, 1'b0}, 16'h1111);
        ld({10'd5, 5'd2, 1'b0}, 16'h2222);
        ld({10'd5, 5'd31, 1'b0}, 16'h3333);
        ld({10'd5, 5'd9, 1'b0}, 16'h4444);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) ld({10'd5, 5'd9, 1'b0}, 16'h5a00);
            if (k == 1) cmd(8'h11, 0);
            if (k == 2) begin
                ee_busy <= 1'b1;
                cmd(`CMD_ERASE, 0);
                rd(`ADDR_STAT, 32'h4, 32'h4, 2'b00);
                chk({31'h0, blocked}, 32'h1);
                ee_busy <= 1'b0;
            end
            if (k == 3) begin
                sys_rst <= 1'b1;
                repeat (2) @(posedge core_clk);
                sys_rst <= 1'b0;
                @(posedge core_clk);
            end
            if (k > 0) ld({10'd5, 5'd9, 1'b0}, 16'h6b00 + 16'(k));
            n_wr = 0;
            wr(`ADDR_PTR, {16'h0, 10'd5, 6'd0});
            cmd(`CMD_WRITE, 0);
            settle(1'b1);
            chk(n_wr, 32);
            chk({22'h0, last_page}, 32'd5);
            chk({16'h0, seen[9]}, k > 0 ? 32'h6b00 + k : 32'h1111);
            if (k == 0) chk({seen[2], seen[31]}, 32'h22223333);
        end
        chk(n_er, 1);
        wr(`ADDR_PTR, 32'h0abd);
        core.lpm();
        @(posedge core_clk);
        chk({16'h0, lpm_addr}, 32'h0abd);
        rd(4'h2, 32'hffffffff, 32'h0, 2'b10);
        wr(4'h1, 32'h0, 2'b10);
        rd(`ADDR_PTR, 32'hffff, 32'h0abd, 2'b00);
        stop_test();
    end
endmodule // test_flash_self_program_sequencer
